// [eeprom_access_defines.vh]
// Constants for the EEPROM access controller: I/O offsets, control bit positions, timing.
// Assumes an 8-bit I/O register port with separate write and read strobes.
`ifndef EEPROM_ACCESS_DEFINES_VH
`define EEPROM_ACCESS_DEFINES_VH
// ****************************************
// Register offsets (I/O space)
// ****************************************
`define EE_CONTROL_OFFSET 6'h1F
`define EE_DATA_OFFSET 6'h20
`define EE_ADDRESS_LOW_OFFSET 6'h21
`define EE_ADDRESS_HIGH_OFFSET 6'h22
// ****************************************
// Control bit positions
// ****************************************
`define READ_STROBE_BIT 0
`define WRITE_STROBE_BIT 1
`define MASTER_WRITE_ENABLE_BIT 2
`define READY_INTERRUPT_ENABLE_BIT 3
// ****************************************
// Timing and array address width
// ****************************************
`define MASTER_ENABLE_CYCLES 3'h4
`define WRITE_STALL_CYCLES 3'h2
`define READ_STALL_CYCLES 3'h4
`define WRITE_OSC_CYCLES 27072
`define ADDRESS_WIDTH 11
`endif

// [rc_write_timer.v]
// Write access timer counting calibrated RC oscillator ticks.
// Assumes osc_tick is a one-cycle enable pulse from the oscillator divider.
`timescale 1ns/10ps
`include "eeprom_access_defines.vh"
module rc_write_timer #(
  parameter WRITE_OSC_CYCLES = `WRITE_OSC_CYCLES
)
(
  input wire clock,
  input wire rstn,
  input wire start,
  input wire osc_tick,
  output reg busy_r,
  output reg done_r
);
  localparam [15:0] LAST_TICK = WRITE_OSC_CYCLES - 1;
  reg [15:0] count_r;
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      busy_r <= 1'b0;
      count_r <= 16'h0000;
      done_r <= 1'b0;
    end
    else
    begin
      done_r <= 1'b0;
      if (start && !busy_r)
      begin
        busy_r <= 1'b1;
        count_r <= 16'h0000;
      end
      else if (busy_r && osc_tick)
      begin
        if (count_r == LAST_TICK)
        begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end
        else
          count_r <= count_r + 16'h0001;
      end
    end
  end
endmodule // rc_write_timer

// [cpu_stall_counter.v]
// Stall counter holding the CPU for a fixed number of cycles after an access.
// Assumes load is a one-cycle pulse and the CPU honours cpu_stall.
`timescale 1ns/10ps
module cpu_stall_counter (
  input wire clock,
  input wire rstn,
  input wire load,
  input wire [2:0] cycles,
  output reg stall_r
);
  reg [2:0] left_r;
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      left_r <= 3'h0;
      stall_r <= 1'b0;
    end
    else if (load)
    begin
      left_r <= cycles - 3'h1;
      stall_r <= 1'b1;
    end
    else if (left_r != 3'h0)
      left_r <= left_r - 3'h1;
    else
      stall_r <= 1'b0;
  end
endmodule // cpu_stall_counter

// [eeprom_access_controller.v]
// EEPROM access controller: address, data and control registers on the CPU I/O port.
// Assumes a byte EEPROM array with one-cycle read and a level programming request.
`timescale 1ns/10ps
`include "eeprom_access_defines.vh"
module eeprom_access_controller #(
  parameter WRITE_OSC_CYCLES = `WRITE_OSC_CYCLES
)
(
  input wire clock,
  input wire rstn,
  input wire [5:0] io_addr,
  input wire io_write,
  input wire io_read,
  input wire [7:0] io_wdata,
  output reg [7:0] io_rdata_r,
  input wire global_interrupt_flag,
  input wire flash_program_busy,
  input wire osc_tick,
  input wire large_array,
  output reg ready_irq_r,
  output wire cpu_stall,
  output reg [10:0] array_addr_r,
  output reg [7:0] array_wdata_r,
  output reg array_program_r,
  output reg array_read_r,
  input wire [7:0] array_rdata
);
  // ****************************************
  // Registers
  // ****************************************
  reg [10:0] ee_address_r;
  reg [7:0] ee_data_r;
  reg ready_interrupt_enable_r;
  reg master_write_enable_r;
  reg [2:0] mwe_count_r;
  reg read_pending_r;
  reg [3:0] ctrl_wdata;
  reg write_start;
  reg read_start;
  wire timer_busy;
  wire timer_done;
  wire stall_w;
  wire stall_r;
  wire write_strobe;
  wire ctrl_wr;
  assign ctrl_wr = io_write && (io_addr == `EE_CONTROL_OFFSET);
  // Strobe is the timer's own busy flag, so it survives a CPU reset only if
  // the timer is reset by power-on; here both share rstn, a known limitation.
  assign write_strobe = timer_busy;
  assign cpu_stall = stall_w | stall_r;
  // ****************************************
  // Strobe decode
  // ****************************************
  always @*
  begin
    ctrl_wdata = io_wdata[3:0];
    write_start = ctrl_wr && ctrl_wdata[`WRITE_STROBE_BIT] && master_write_enable_r
                  && !timer_busy && !flash_program_busy;
    read_start = ctrl_wr && ctrl_wdata[`READ_STROBE_BIT] && !timer_busy;
  end
  rc_write_timer #(
    .WRITE_OSC_CYCLES(WRITE_OSC_CYCLES)
  ) u_timer (
    .clock(clock),
    .rstn(rstn),
    .start(write_start),
    .osc_tick(osc_tick),
    .busy_r(timer_busy),
    .done_r(timer_done)
  );
  cpu_stall_counter u_wstall (
    .clock(clock),
    .rstn(rstn),
    .load(write_start),
    .cycles(`WRITE_STALL_CYCLES),
    .stall_r(stall_w)
  );
  cpu_stall_counter u_rstall (
    .clock(clock),
    .rstn(rstn),
    .load(read_start),
    .cycles(`READ_STALL_CYCLES),
    .stall_r(stall_r)
  );
  // ****************************************
  // Register writes and array control
  // ****************************************
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      ee_address_r <= 11'h000;
      ee_data_r <= 8'h00;
      ready_interrupt_enable_r <= 1'b0;
      master_write_enable_r <= 1'b0;
      mwe_count_r <= 3'h0;
      read_pending_r <= 1'b0;
      array_addr_r <= 11'h000;
      array_wdata_r <= 8'h00;
      array_program_r <= 1'b0;
      array_read_r <= 1'b0;
    end
    else
    begin
      array_read_r <= 1'b0;
      read_pending_r <= 1'b0;
      if (io_write && !timer_busy && io_addr == `EE_ADDRESS_LOW_OFFSET)
        ee_address_r[7:0] <= io_wdata;
      if (io_write && !timer_busy && io_addr == `EE_ADDRESS_HIGH_OFFSET)
        ee_address_r[10:8] <= {io_wdata[2] & large_array, io_wdata[1:0]};
      if (io_write && io_addr == `EE_DATA_OFFSET)
        ee_data_r <= io_wdata;
      if (ctrl_wr)
        ready_interrupt_enable_r <= ctrl_wdata[`READY_INTERRUPT_ENABLE_BIT];
      // Master enable window
      if (ctrl_wr && ctrl_wdata[`MASTER_WRITE_ENABLE_BIT] && !master_write_enable_r)
      begin
        master_write_enable_r <= 1'b1;
        mwe_count_r <= `MASTER_ENABLE_CYCLES - 3'h1;
      end
      else if (write_start)
        master_write_enable_r <= 1'b0;
      else if (master_write_enable_r)
      begin
        if (mwe_count_r == 3'h0)
          master_write_enable_r <= 1'b0;
        else
          mwe_count_r <= mwe_count_r - 3'h1;
      end
      if (write_start)
      begin
        array_addr_r <= ee_address_r;
        array_wdata_r <= ee_data_r;
        array_program_r <= 1'b1;
      end
      else if (timer_done)
        array_program_r <= 1'b0;
      if (read_start)
      begin
        array_addr_r <= ee_address_r;
        array_read_r <= 1'b1;
        read_pending_r <= 1'b1;
      end
      // Array returns data in the same cycle that array_read_r is high; a CPU data write
      // in the same cycle loses to the fetched byte.
      if (read_pending_r)
        ee_data_r <= array_rdata;
    end
  end
  // ****************************************
  // Read mux and interrupt
  // ****************************************
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      io_rdata_r <= 8'h00;
      ready_irq_r <= 1'b0;
    end
    else
    begin
      // Waits for the array request to drop too, so no irq while programming ends
      ready_irq_r <= ready_interrupt_enable_r && global_interrupt_flag && !write_strobe && !array_program_r;
      io_rdata_r <= 8'h00;
      if (io_read)
      begin
        case (io_addr)
          `EE_CONTROL_OFFSET:
            io_rdata_r <= {4'h0, ready_interrupt_enable_r, master_write_enable_r, write_strobe, 1'b0};
          `EE_DATA_OFFSET:
            io_rdata_r <= ee_data_r;
          `EE_ADDRESS_LOW_OFFSET:
            io_rdata_r <= ee_address_r[7:0];
          `EE_ADDRESS_HIGH_OFFSET:
            io_rdata_r <= {5'h00, ee_address_r[10:8]};
          default:
            io_rdata_r <= 8'h00;
        endcase
      end
    end
  end
endmodule // eeprom_access_controller

// [eeprom_array_model.sv]
// Behavioural EEPROM byte array on the far side of the controller.
// Assumes one program request per level pulse of array_program_r.
`timescale 1ns/10ps
module eeprom_array_model (
  input wire clock,
  input wire [10:0] array_addr_r,
  input wire [7:0] array_wdata_r,
  input wire array_program_r,
  input wire array_read_r,
  output wire [7:0] array_rdata
);
  reg [7:0] mem [0:2047];
  reg [7:0] junk_r = 8'h00;
  reg prog_r = 1'b0;
  reg read_r = 1'b0;
  // Bus churns outside a read and the cycle after it, so stale data cannot pass
  assign array_rdata = (array_read_r || read_r) ? mem[array_addr_r] : junk_r;
  always @(posedge clock)
  begin
    junk_r <= junk_r + 8'h5B;
    read_r <= array_read_r;
    prog_r <= array_program_r;
    if (array_program_r && !prog_r)
      mem[array_addr_r] <= array_wdata_r;
  end
endmodule // eeprom_array_model

// [eeprom_access_controller_monitor.sv]
// Port checker for the EEPROM access controller.
// Bound to every controller instance; sees its ports only.
`timescale 1ns/10ps
module eeprom_access_controller_monitor #(
  parameter WRITE_OSC_CYCLES = 27072
)
(
  input wire clock,
  input wire rstn,
  input wire [5:0] io_addr,
  input wire io_read,
  input wire [7:0] io_rdata_r,
  input wire global_interrupt_flag,
  input wire flash_program_busy,
  input wire osc_tick,
  input wire ready_irq_r,
  input wire cpu_stall,
  input wire [10:0] array_addr_r,
  input wire array_program_r,
  input wire array_read_r
);
  // ****
  // Ticks seen during the running write
  // ****
  reg [15:0] tick_r;
  always @(posedge clock or negedge rstn)
    if (!rstn)
      tick_r <= 16'h0000;
    else
      tick_r <= array_program_r ? tick_r + {15'h0000, osc_tick} : 16'h0000;
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  AST_CTRL_RSVD: assert property ($past(io_read && io_addr == 6'h1F) |-> io_rdata_r[7:4] == 4'h0)
    else $error("control reserved bits set");
  AST_ADDR_RSVD: assert property ($past(io_read && io_addr == 6'h22) |-> io_rdata_r[7:3] == 5'h00)
    else $error("address reserved bits set");
  AST_WRITE_STALL: assert property ($rose(array_program_r) |-> cpu_stall [*2])
    else $error("write stall short");
  AST_READ_STALL: assert property ($rose(array_read_r) |-> cpu_stall [*4])
    else $error("read stall short");
  AST_NO_READ_BUSY: assert property (array_program_r |-> !array_read_r)
    else $error("read during write");
  AST_ADDR_HELD: assert property (array_program_r && $past(array_program_r) |-> $stable(array_addr_r))
    else $error("address moved during write");
  AST_FLASH_BLOCK: assert property ($rose(array_program_r) |-> !$past(flash_program_busy))
    else $error("write while flash busy");
  AST_IRQ_CAUSE: assert property (ready_irq_r |-> $past(global_interrupt_flag) && !$past(array_program_r))
    else $error("irq without cause");
  AST_TICK_MAX: assert property (array_program_r |-> tick_r <= WRITE_OSC_CYCLES)
    else $error("write too long");
  AST_TICK_MIN: assert property ($fell(array_program_r) |-> tick_r >= WRITE_OSC_CYCLES)
    else $error("write too short");
  cover property ($rose(array_program_r));
  cover property ($rose(array_read_r));
  cover property ($rose(ready_irq_r));
endmodule // eeprom_access_controller_monitor
bind eeprom_access_controller eeprom_access_controller_monitor #(.WRITE_OSC_CYCLES(WRITE_OSC_CYCLES)) u_mon (.*);

// [eeprom_access_controller_test.sv]
// Self-checking bench for the EEPROM access controller.
// Uses a short write timer and an oscillator tick every fourth cycle.
`timescale 1ns/10ps
`include "eeprom_access_defines.vh"
module eeprom_access_controller_test;
  localparam [5:0] CT = `EE_CONTROL_OFFSET;
  localparam [5:0] DT = `EE_DATA_OFFSET;
  localparam [5:0] AL = `EE_ADDRESS_LOW_OFFSET;
  localparam [5:0] AH = `EE_ADDRESS_HIGH_OFFSET;
  reg clock = 1'b0;
  reg rstn = 1'b0;
  reg [5:0] io_addr = 6'h00;
  reg io_write = 1'b0;
  reg io_read = 1'b0;
  reg [7:0] io_wdata = 8'h00;
  reg global_interrupt_flag = 1'b0;
  reg flash_program_busy = 1'b0;
  reg [1:0] tick_r = 2'h0;
  reg large_array = 1'b1;
  wire cpu_stall;
  wire [7:0] io_rdata_r;
  wire [7:0] array_wdata_r;
  wire [7:0] array_rdata;
  wire [10:0] array_addr_r;
  wire ready_irq_r;
  wire array_program_r;
  wire array_read_r;
  integer failures = 0;
  integer comparisons = 0;
  always #10 clock = ~clock;
  always @(negedge clock) tick_r <= tick_r + 2'h1;
  eeprom_access_controller #(.WRITE_OSC_CYCLES(8)) u_eeprom_access_controller (
    .clock(clock), .rstn(rstn), .io_addr(io_addr), .io_write(io_write), .io_read(io_read),
    .io_wdata(io_wdata), .io_rdata_r(io_rdata_r), .global_interrupt_flag(global_interrupt_flag),
    .flash_program_busy(flash_program_busy), .osc_tick(tick_r == 2'h3), .large_array(large_array),
    .ready_irq_r(ready_irq_r), .cpu_stall(cpu_stall), .array_addr_r(array_addr_r), .array_wdata_r(array_wdata_r),
    .array_program_r(array_program_r), .array_read_r(array_read_r), .array_rdata(array_rdata));
  eeprom_array_model u_eeprom_array_model (.clock(clock), .array_addr_r(array_addr_r),
    .array_wdata_r(array_wdata_r), .array_program_r(array_program_r), .array_read_r(array_read_r),
    .array_rdata(array_rdata));
  // ****
  // Access tasks
  // ****
  task chk(input [10:0] seen, input [10:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp)
      begin
        failures = failures + 1;
        $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task print_verdict;
    begin
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  task wr(input [5:0] a, input [7:0] d);
    begin
      @(negedge clock);
      io_addr = a;
      io_wdata = d;
      io_write = 1'b1;
      @(negedge clock);
      io_write = 1'b0;
    end
  endtask
  task rd(input [5:0] a, input [7:0] exp);
    begin
      @(negedge clock);
      io_addr = a;
      io_read = 1'b1;
      @(negedge clock);
      io_read = 1'b0;
      chk(io_rdata_r, exp);
    end
  endtask
  task wait_done;
    integer i;
    begin
      for (i = 0; i < 300 && array_program_r; i = i + 1)
        @(negedge clock);
      if (array_program_r)
      begin
        failures = failures + 1;
        print_verdict;
      end
    end
  endtask
  initial
  begin
    repeat (2) @(negedge clock);
    rstn = 1'b1;
    rd(CT, 8'h00);
    wr(CT, 8'hF8);
    rd(CT, 8'h08);
    wr(AH, 8'hFF);
    rd(AH, 8'h07);
    global_interrupt_flag = 1'b1;
    @(negedge clock);
    chk(ready_irq_r, 1'b1);
    global_interrupt_flag = 1'b0;
    @(negedge clock);
    chk(ready_irq_r, 1'b0);
    wr(CT, 8'h0A);
    rd(CT, 8'h08);
    chk(array_program_r, 1'b0);
    wr(CT, 8'h0C);
    rd(CT, 8'h0C);
    repeat (2) @(negedge clock);
    rd(CT, 8'h08);
    wr(CT, 8'h0A);
    rd(CT, 8'h08);
    wr(AL, 8'h5A);
    wr(AH, 8'h05);
    wr(DT, 8'hC3);
    wr(CT, 8'h0C);
    wr(CT, 8'h0A);
    global_interrupt_flag = 1'b1;
    @(negedge clock);
    chk(cpu_stall, 1'b1);
    chk(array_program_r, 1'b1);
    chk(array_addr_r, 11'h55A);
    chk(array_wdata_r, 8'hC3);
    chk(ready_irq_r, 1'b0);
    rd(CT, 8'h0A);
    chk(cpu_stall, 1'b0);
    wr(AL, 8'h00);
    rd(AL, 8'h5A);
    wr(CT, 8'h09);
    wait_done;
    repeat (2) @(negedge clock);
    chk(ready_irq_r, 1'b1);
    rd(CT, 8'h08);
    wr(DT, 8'h11);
    wr(CT, 8'h09);
    repeat (2) @(negedge clock);
    rd(DT, 8'hC3);
    flash_program_busy = 1'b1;
    wr(CT, 8'h0C);
    wr(CT, 8'h0A);
    rd(CT, 8'h0C);
    chk(array_program_r, 1'b0);
    large_array = 1'b0;
    wr(AH, 8'hFF);
    rd(AH, 8'h03);
    print_verdict;
  end
endmodule // eeprom_access_controller_test
